// *** core/mio_pkg.sv ***
// Constants for the three-port multiplexed I/O block.
// Assumes a 32-bit Avalon-MM slave with byte addresses.
// ------------------------------------------------------------
// ------------------------------------------------------------
package mio_pkg;
  // Geometry
  localparam int PW    = 8;
  localparam int NPORT = 3;
  localparam int PD    = 0;
  localparam int PE    = 1;
  localparam int PF    = 2;

  // Register byte offsets, one 32-bit word each
  localparam logic [5:0] STRIDE     = 6'h0C;
  localparam logic [5:0] PIN_OFS    = 6'h00;
  localparam logic [5:0] LAT_OFS    = 6'h04;
  localparam logic [5:0] DIR_OFS    = 6'h08;
  localparam logic [5:0] PSP_OFS    = 6'h24;
  localparam logic [5:0] IRQ_ST_OFS = 6'h28;
  localparam logic [5:0] IRQ_CL_OFS = 6'h2C;
  localparam logic [5:0] IRQ_EN_OFS = 6'h30;
  localparam logic [5:0] ANA_OFS    = 6'h34;
  localparam logic [5:0] FUNC_OFS   = 6'h38;

  // Parallel slave control fields
  localparam int IN_FULL_BIT  = 7;
  localparam int OUT_FULL_BIT = 6;
  localparam int OVERRUN_BIT  = 5;
  localparam int MODE_BIT     = 4;

  // Fifth port pin roles
  localparam int RD_BIT  = 0;
  localparam int WR_BIT  = 1;
  localparam int CS_BIT  = 2;
  localparam int CCP_BIT = 7;

  // Interrupt status layout
  localparam int NIRQ    = 3;
  localparam int IRQ_IN_FULL  = 0;
  localparam int IRQ_OUT_FREE = 1;
  localparam int IRQ_OVF      = 2;

  // Reset values
  localparam logic [7:0] DIR_RST = 8'hFF;
  localparam logic [7:0] LAT_RST = 8'h00;
  localparam logic [6:0] ANA_RST = 7'h7F;
endpackage

// *** core/mio_ports.sv ***
// Three 8-bit multiplexed I/O ports with parallel slave hooks.
// Assumes a synchronous parallel slave engine and capture unit
// outside, and pin inputs already synchronous to mclk.
`timescale 1ns/1ns
`default_nettype none

module mio_ports (
  // Clock and resets
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic        sys_reset,
  // Avalon-MM slave
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Fourth port pins
  input  wire logic [7:0]  pd_in,
  output logic      [7:0]  pd_out,
  output logic      [7:0]  pd_oe,
  // Fifth port pins
  input  wire logic [7:0]  pe_in,
  output logic      [7:0]  pe_out,
  output logic      [7:0]  pe_oe,
  // Sixth port pins
  input  wire logic [7:0]  pf_in,
  output logic      [7:0]  pf_out,
  output logic      [7:0]  pf_oe,
  // Parallel slave engine
  output logic             psp_mode,
  output logic      [7:0]  psp_data_in,
  output logic             psp_rd_n,
  output logic             psp_wr_n,
  output logic             psp_cs_n,
  input  wire logic [7:0]  psp_data_out,
  input  wire logic        psp_data_oe,
  input  wire logic        psp_in_full,
  input  wire logic        psp_out_full,
  input  wire logic        psp_overflow,
  // Capture/compare unit
  output logic             ccp_sel,
  output logic             ccp_capture_in,
  input  wire logic        ccp_out,
  input  wire logic        ccp_out_en,
  // Analog select and interrupt
  output logic      [6:0]  analog_sel,
  output logic             irq
);

  // ----------------------------------------------------------
  // State
  // ----------------------------------------------------------
  logic [7:0]      dir_reg [mio_pkg::NPORT];  // Direction
  logic [7:0]      dir_next[mio_pkg::NPORT];
  logic [7:0]      lat_reg [mio_pkg::NPORT];  // Output latch
  logic [7:0]      lat_next[mio_pkg::NPORT];
  logic [7:0]      oe_reg  [mio_pkg::NPORT];  // Pin enables
  logic [7:0]      oe_next [mio_pkg::NPORT];
  logic [7:0]      out_reg [mio_pkg::NPORT];  // Pin data
  logic [7:0]      out_next[mio_pkg::NPORT];
  logic [7:0]      pin_in  [mio_pkg::NPORT];  // Pin levels
  logic            mode_reg, mode_next;       // Slave mode
  logic            ovf_reg, ovf_next;         // Overflow
  logic [6:0]      ana_reg, ana_next;         // Analog pins
  logic            func_reg, func_next;       // CCP on pin
  logic [2:0]      st_reg, st_next;           // Irq status
  logic [2:0]      en_reg, en_next;           // Irq enable
  logic [2:0]      ev;                        // Irq events
  logic            in_full_q, out_full_q;     // Edge history
  logic            ack_reg, ack_next;         // Bus answer
  logic [31:0]     rd_reg, rd_next;           // Read data
  logic [7:0]      sdat_reg, sdat_next;       // Bus to engine
  logic [3:0]      smp_reg, smp_next;         // Strobes, ccp
  logic            req, wr_ok;
  logic [7:0]      wdat;

  assign pin_in[mio_pkg::PD] = pd_in;
  assign pin_in[mio_pkg::PE] = pe_in;
  assign pin_in[mio_pkg::PF] = pf_in;

  // ----------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------
  // One wait cycle per access, so read data comes from a flop
  assign req             = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_reg;
  // Only byte lane 0 holds data; upper lanes are ignored
  assign wr_ok = avs_write & ack_reg & avs_byteenable[0];
  assign wdat  = avs_writedata[7:0];
  assign ack_next = req & ~ack_reg;

  // Read mux, captured in the wait cycle
  always_comb begin
    rd_next = rd_reg;
    if (req && !ack_reg) begin
      rd_next = 32'h0000_0000;
      for (int p = 0; p < mio_pkg::NPORT; p++) begin
        if (avs_address == 6'(p * mio_pkg::STRIDE) + mio_pkg::PIN_OFS) begin
          rd_next[7:0] = pin_in[p];
          if (p == mio_pkg::PF) begin
            // Analog pins read as zero
            rd_next[6:0] = pin_in[p][6:0] & ~ana_reg;
          end
        end
        if (avs_address == 6'(p * mio_pkg::STRIDE) + mio_pkg::LAT_OFS) begin
          rd_next[7:0] = lat_reg[p];
        end
        if (avs_address == 6'(p * mio_pkg::STRIDE) + mio_pkg::DIR_OFS) begin
          rd_next[7:0] = dir_reg[p];
        end
      end
      case (avs_address)
        mio_pkg::PSP_OFS: begin
          // Low nibble unimplemented
          rd_next[7:0] = {psp_in_full, psp_out_full,
                          ovf_reg, mode_reg, 4'h0};
        end
        mio_pkg::IRQ_ST_OFS: begin
          rd_next[2:0] = st_reg;
        end
        mio_pkg::IRQ_EN_OFS: begin
          rd_next[2:0] = en_reg;
        end
        mio_pkg::ANA_OFS: begin
          rd_next[6:0] = ana_reg;
        end
        mio_pkg::FUNC_OFS: begin
          rd_next[0] = func_reg;
        end
        default: begin
          // Clear register and unmapped words read zero
        end
      endcase
    end
  end

  // ----------------------------------------------------------
  // Register file
  // ----------------------------------------------------------
  // Events: input buffer filled, output buffer emptied, overrun
  assign ev[mio_pkg::IRQ_IN_FULL]  = mode_reg & psp_in_full & ~in_full_q;
  assign ev[mio_pkg::IRQ_OUT_FREE] = mode_reg & ~psp_out_full & out_full_q;
  assign ev[mio_pkg::IRQ_OVF] = mode_reg & psp_overflow;

  always_comb begin
    for (int p = 0; p < mio_pkg::NPORT; p++) begin
      dir_next[p] = dir_reg[p];
      lat_next[p] = lat_reg[p];
      if (wr_ok) begin
        // Pin and latch addresses both write the latch
        if (avs_address == 6'(p * mio_pkg::STRIDE) + mio_pkg::PIN_OFS ||
            avs_address == 6'(p * mio_pkg::STRIDE) + mio_pkg::LAT_OFS) begin
          lat_next[p] = wdat;
        end
        // Stored as written even while a peripheral overrides
        if (avs_address == 6'(p * mio_pkg::STRIDE) + mio_pkg::DIR_OFS) begin
          dir_next[p] = wdat;
        end
      end
    end
    mode_next = mode_reg;
    ana_next  = ana_reg;
    func_next = func_reg;
    en_next   = en_reg;
    ovf_next  = ovf_reg;
    st_next   = st_reg;
    if (wr_ok) begin
      case (avs_address)
        mio_pkg::PSP_OFS: begin
          mode_next = wdat[mio_pkg::MODE_BIT];
          // Software clears the overrun flag by writing zero
          if (!wdat[mio_pkg::OVERRUN_BIT]) begin
            ovf_next = 1'b0;
          end
        end
        mio_pkg::IRQ_CL_OFS: begin
          st_next = st_reg & ~wdat[2:0];
        end
        mio_pkg::IRQ_EN_OFS: begin
          en_next = wdat[2:0];
        end
        mio_pkg::ANA_OFS: begin
          ana_next = wdat[6:0];
        end
        mio_pkg::FUNC_OFS: begin
          func_next = wdat[0];
        end
        default: begin
          // Read-only or unmapped: write dropped
        end
      endcase
    end
    // Hardware sets win over a clear in the same cycle
    if (mode_reg && psp_overflow) begin
      ovf_next = 1'b1;
    end
    st_next = st_next | ev;
    // Soft reset: directions to inputs, latches kept
    if (sys_reset) begin
      for (int p = 0; p < mio_pkg::NPORT; p++) begin
        dir_next[p] = mio_pkg::DIR_RST;
      end
      mode_next = 1'b0;
      ovf_next  = 1'b0;
      ana_next  = mio_pkg::ANA_RST;
      func_next = 1'b0;
      st_next   = 3'h0;
      en_next   = 3'h0;
    end
  end

  // ----------------------------------------------------------
  // Pin multiplexing
  // ----------------------------------------------------------
  // Overrides act here only; dir_reg never sees them
  always_comb begin
    for (int p = 0; p < mio_pkg::NPORT; p++) begin
      oe_next[p]  = ~dir_reg[p];
      out_next[p] = lat_reg[p];
    end
    if (mode_reg) begin
      // Engine drives the bus only during its read cycle
      oe_next[mio_pkg::PD]  = {mio_pkg::PW{psp_data_oe}};
      out_next[mio_pkg::PD] = psp_data_out;
      // Strobes and select forced to inputs
      oe_next[mio_pkg::PE][mio_pkg::CS_BIT:0] = 3'b000;
    end
    if (func_reg) begin
      oe_next[mio_pkg::PE][mio_pkg::CCP_BIT]  = ccp_out_en;
      out_next[mio_pkg::PE][mio_pkg::CCP_BIT] = ccp_out;
    end
    // Analog pins never driven digitally
    oe_next[mio_pkg::PF][6:0] = oe_next[mio_pkg::PF][6:0] & ~ana_reg;
    sdat_next = pd_in;
    // Strobes idle high outside slave mode
    smp_next[0] = mode_reg ? pe_in[mio_pkg::RD_BIT] : 1'b1;
    smp_next[1] = mode_reg ? pe_in[mio_pkg::WR_BIT] : 1'b1;
    smp_next[2] = mode_reg ? pe_in[mio_pkg::CS_BIT] : 1'b1;
    smp_next[3] = pe_in[mio_pkg::CCP_BIT];
  end

  // ----------------------------------------------------------
  // Registers
  // ----------------------------------------------------------
  // Power-on reset clears latches; soft reset does not
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      for (int p = 0; p < mio_pkg::NPORT; p++) begin
        dir_reg[p] <= mio_pkg::DIR_RST;
        lat_reg[p] <= mio_pkg::LAT_RST;
        oe_reg[p]  <= 8'h00;
        out_reg[p] <= 8'h00;
      end
      mode_reg <= 1'b0;
      ovf_reg  <= 1'b0;
      ana_reg  <= mio_pkg::ANA_RST;
      func_reg <= 1'b0;
      st_reg   <= 3'h0;
      en_reg   <= 3'h0;
      in_full_q  <= 1'b0;
      out_full_q <= 1'b0;
      ack_reg  <= 1'b0;
      rd_reg   <= 32'h0000_0000;
      sdat_reg <= 8'h00;
      smp_reg  <= 4'hF;
    end else begin
      for (int p = 0; p < mio_pkg::NPORT; p++) begin
        dir_reg[p] <= dir_next[p];
        lat_reg[p] <= lat_next[p];
        oe_reg[p]  <= oe_next[p];
        out_reg[p] <= out_next[p];
      end
      mode_reg <= mode_next;
      ovf_reg  <= ovf_next;
      ana_reg  <= ana_next;
      func_reg <= func_next;
      st_reg   <= st_next;
      en_reg   <= en_next;
      in_full_q  <= psp_in_full;
      out_full_q <= psp_out_full;
      ack_reg  <= ack_next;
      rd_reg   <= rd_next;
      sdat_reg <= sdat_next;
      smp_reg  <= smp_next;
    end
  end

  // ----------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------
  assign avs_readdata   = rd_reg;
  assign pd_out         = out_reg[mio_pkg::PD];
  assign pd_oe          = oe_reg[mio_pkg::PD];
  assign pe_out         = out_reg[mio_pkg::PE];
  assign pe_oe          = oe_reg[mio_pkg::PE];
  assign pf_out         = out_reg[mio_pkg::PF];
  assign pf_oe          = oe_reg[mio_pkg::PF];
  assign psp_mode       = mode_reg;
  assign psp_data_in    = sdat_reg;
  assign psp_rd_n       = smp_reg[0];
  assign psp_wr_n       = smp_reg[1];
  assign psp_cs_n       = smp_reg[2];
  assign ccp_capture_in = smp_reg[3];
  assign ccp_sel        = func_reg;
  assign analog_sel     = ana_reg;
  assign irq            = |(st_reg & en_reg);

  // ----------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);

  dir_input_a: assert property (
    !mode_reg |=> ((pd_oe & $past(dir_reg[mio_pkg::PD])) == 8'h00))
    else $error("input pin still driven");

  latch_drive_a: assert property (
    !mode_reg && !func_reg |=>
      pe_oe == ~$past(dir_reg[mio_pkg::PE]) &&
      pe_out == $past(lat_reg[mio_pkg::PE]))
    else $error("output pin not from latch");

  latch_read_a: assert property (
    avs_read && !avs_waitrequest &&
      avs_address == mio_pkg::LAT_OFS |->
      avs_readdata[7:0] == lat_reg[mio_pkg::PD])
    else $error("latch read wrong");

  pin_read_a: assert property (
    avs_read && avs_waitrequest &&
      avs_address == mio_pkg::PIN_OFS |=>
      avs_readdata[7:0] == $past(pd_in))
    else $error("pin read wrong");

  psp_bus_a: assert property (
    mode_reg |=> pd_oe == {8{$past(psp_data_oe)}} &&
      psp_data_in == $past(pd_in))
    else $error("slave bus not routed");

  psp_strobe_a: assert property (
    mode_reg |=> pe_oe[2:0] == 3'b000 &&
      psp_rd_n == $past(pe_in[0]) &&
      psp_wr_n == $past(pe_in[1]) &&
      psp_cs_n == $past(pe_in[2]))
    else $error("strobe not routed");

  ccp_pin_a: assert property (
    func_reg |=> pe_oe[7] == $past(ccp_out_en) &&
      ccp_capture_in == $past(pe_in[7]))
    else $error("ccp pin not routed");

  psp_nibble_a: assert property (
    avs_read && !avs_waitrequest &&
      avs_address == mio_pkg::PSP_OFS |->
      avs_readdata[3:0] == 4'h0 && avs_readdata[31:8] == '0)
    else $error("control low bits set");

  analog_pin_a: assert property (
    ##1 (pf_oe[6:0] & $past(ana_reg)) == 7'h00)
    else $error("analog pin driven");

  override_keep_a: assert property (
    wr_ok && avs_address == mio_pkg::STRIDE + mio_pkg::DIR_OFS
      && !sys_reset |=> dir_reg[mio_pkg::PE] == $past(wdat))
    else $error("direction write lost");

  soft_reset_a: assert property (
    sys_reset && !wr_ok |=> dir_reg[mio_pkg::PD] == mio_pkg::DIR_RST &&
      lat_reg[mio_pkg::PD] == $past(lat_reg[mio_pkg::PD]))
    else $error("soft reset wrong");

endmodule // mio_ports

`default_nettype wire

// *** testbench/mio_pad_model.sv ***
// Behavioural model of the outside circuitry on one 8-bit port.
// Assumes one clock; a pin that nobody drives shows the inverse of its
// last level, so a floating line never passes for a stable value.
`timescale 1ns/1ns
`default_nettype none

module mio_pad_model (
  // Clock
  input  wire logic       mclk,
  // Design drive
  input  wire logic [7:0] drv_out,
  input  wire logic [7:0] drv_oe,
  // Outside drive
  input  wire logic [7:0] ext_val,
  input  wire logic       ext_en,
  // Resolved pin levels
  output logic      [7:0] pin
);
  logic [7:0] last_pin = 8'h00; // Level seen at the previous edge

  // ----------------------------------------------------------
  // Pin resolution
  // ----------------------------------------------------------
  // The design's driver wins; the outside only drives a released pin
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pin[i] = drv_oe[i] ? drv_out[i] : (ext_en ? ext_val[i] : ~last_pin[i]);
    end
  end

  // Remember the level for the floating case
  always_ff @(posedge mclk) begin
    last_pin <= pin;
  end
endmodule // mio_pad_model

`default_nettype wire

// *** testbench/multiplexed_io_ports_d_e_f_bench.sv ***
// Self-checking bench for the three-port multiplexed I/O block.
// Assumes the 10 MHz clock, one wait cycle per bus access, and pads
// modelled outside by mio_pad_model.
`timescale 1ns/1ns
`default_nettype none

module multiplexed_io_ports_d_e_f_bench;
  logic        mclk = 1'b0, rstn = 1'b0, sys_reset = 1'b0;     // Clock, resets
  logic [5:0]  avs_address = 6'h00;                            // Bus address
  logic        avs_read = 1'b0, avs_write = 1'b0;              // Bus requests
  logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata;    // Bus data
  logic        avs_waitrequest, irq, psp_mode, ccp_sel, ccp_capture_in;
  logic [7:0]  pd_in, pd_out, pd_oe, pe_in, pe_out, pe_oe, pf_in, pf_out, pf_oe;
  logic [7:0]  ext_d = 8'h00, ext_e = 8'h00, ext_f = 8'h00;    // Outside levels
  logic [7:0]  psp_data_in, psp_data_out = 8'h00;              // Engine data
  logic        psp_rd_n, psp_wr_n, psp_cs_n, psp_data_oe = 1'b0;
  logic        psp_in_full = 1'b0, psp_out_full = 1'b0, psp_overflow = 1'b0;
  logic        ccp_out = 1'b0, ccp_out_en = 1'b0;              // Compare drive
  logic [6:0]  analog_sel;                                     // Analog mask
  int          errors = 0, cmp_count = 0;                      // Tallies

  // ----------------------------------------------------------
  // Clock, design and pads
  // ----------------------------------------------------------
  always #50 mclk = ~mclk;

  mio_ports u_dut (.mclk(mclk), .rstn(rstn), .sys_reset(sys_reset),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'h1),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .pd_in(pd_in), .pd_out(pd_out), .pd_oe(pd_oe), .pe_in(pe_in),
    .pe_out(pe_out), .pe_oe(pe_oe), .pf_in(pf_in), .pf_out(pf_out),
    .pf_oe(pf_oe), .psp_mode(psp_mode), .psp_data_in(psp_data_in),
    .psp_rd_n(psp_rd_n), .psp_wr_n(psp_wr_n), .psp_cs_n(psp_cs_n),
    .psp_data_out(psp_data_out), .psp_data_oe(psp_data_oe),
    .psp_in_full(psp_in_full), .psp_out_full(psp_out_full),
    .psp_overflow(psp_overflow), .ccp_sel(ccp_sel),
    .ccp_capture_in(ccp_capture_in), .ccp_out(ccp_out),
    .ccp_out_en(ccp_out_en), .analog_sel(analog_sel), .irq(irq));

  mio_pad_model u_pad_d (.mclk(mclk), .drv_out(pd_out), .drv_oe(pd_oe),
    .ext_val(ext_d), .ext_en(1'b1), .pin(pd_in));
  mio_pad_model u_pad_e (.mclk(mclk), .drv_out(pe_out), .drv_oe(pe_oe),
    .ext_val(ext_e), .ext_en(1'b1), .pin(pe_in));
  mio_pad_model u_pad_f (.mclk(mclk), .drv_out(pf_out), .drv_oe(pf_oe),
    .ext_val(ext_f), .ext_en(1'b1), .pin(pf_in));

  // ----------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Request held until waitrequest is seen low at a rising edge
  task automatic bus_wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge mclk);
    avs_address   <= a;
    avs_writedata <= {24'h0, d};
    avs_write     <= 1'b1;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    avs_write     <= 1'b0;
  endtask

  task automatic chk_rd(input logic [5:0] a, input logic [31:0] exp);
    logic [31:0] d;
    @(posedge mclk);
    avs_address <= a;
    avs_read    <= 1'b1;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read    <= 1'b0;
    check(d, exp);
  endtask

  // ----------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------
  task automatic t_reset;
    ext_f <= 8'hFF;
    tick(2);
    check({pd_oe, pe_oe, pf_oe}, 32'h0000_0000);
    chk_rd(6'h08, 32'h0000_00FF);
    chk_rd(6'h14, 32'h0000_00FF);
    chk_rd(6'h20, 32'h0000_00FF);
    chk_rd(6'h24, 32'h0000_0000);
    chk_rd(6'h34, 32'h0000_007F);
    chk_rd(6'h18, 32'h0000_0080);
  endtask

  // Latch written through the pin address, pins differ from latch
  task automatic t_dir_latch;
    ext_d <= 8'h5A;
    bus_wr(6'h00, 8'hA5);
    tick(2);
    chk_rd(6'h04, 32'h0000_00A5);
    chk_rd(6'h00, 32'h0000_005A);
    bus_wr(6'h08, 8'h0F);
    tick(2);
    check(pd_oe, 8'hF0);
    check(pd_out & pd_oe, 8'hA0);
    chk_rd(6'h00, 32'h0000_00AA);
  endtask

  // Slave mode, strobes, data bus, flags and interrupt
  task automatic t_psp;
    bus_wr(6'h24, 8'h10);
    bus_wr(6'h14, 8'h00);
    ext_e <= 8'h05;
    ext_d <= 8'h3C;
    tick(3);
    check(psp_mode, 1'b1);
    chk_rd(6'h24, 32'h0000_0010);
    check(pe_oe, 8'hF8);
    chk_rd(6'h14, 32'h0000_0000);
    check({psp_cs_n, psp_wr_n, psp_rd_n}, 3'b101);
    check(psp_data_in, 8'h3C);
    psp_data_out <= 8'hC3;
    psp_data_oe  <= 1'b1;
    tick(2);
    check({pd_oe, pd_out}, 16'hFFC3);
    psp_data_oe  <= 1'b0;
    bus_wr(6'h30, 8'h01);
    psp_in_full  <= 1'b1;
    tick(3);
    check(irq, 1'b1);
    chk_rd(6'h28, 32'h0000_0001);
    chk_rd(6'h24, 32'h0000_0090);
    bus_wr(6'h2C, 8'h01);
    tick(2);
    check(irq, 1'b0);
    psp_overflow <= 1'b1;
    tick(1);
    psp_overflow <= 1'b0;
    tick(2);
    check(irq, 1'b0);
    chk_rd(6'h24, 32'h0000_00B0);
    bus_wr(6'h24, 8'h10);
    chk_rd(6'h24, 32'h0000_0090);
    chk_rd(6'h3C, 32'h0000_0000);
    psp_out_full <= 1'b1;
    chk_rd(6'h24, 32'h0000_00D0);
    psp_out_full <= 1'b0;
    tick(2);
    chk_rd(6'h28, 32'h0000_0006);
  endtask

  // Soft reset keeps latches, returns directions to inputs
  task automatic t_soft_reset;
    psp_in_full <= 1'b0;
    sys_reset   <= 1'b1;
    tick(1);
    sys_reset   <= 1'b0;
    tick(2);
    chk_rd(6'h08, 32'h0000_00FF);
    chk_rd(6'h04, 32'h0000_00A5);
    chk_rd(6'h24, 32'h0000_0000);
    check(pd_oe, 8'h00);
  endtask

  // Compare output on the fifth port, sixth port made digital
  task automatic t_ccp_analog;
    bus_wr(6'h38, 8'h01);
    ccp_out    <= 1'b1;
    ccp_out_en <= 1'b1;
    tick(2);
    check({pe_oe[7], pe_out[7]}, 2'b11);
    check(ccp_sel, 1'b1);
    ccp_out_en <= 1'b0;
    ext_e      <= 8'h00;
    tick(3);
    check(ccp_capture_in, 1'b0);
    ext_e      <= 8'h80;
    tick(3);
    check(ccp_capture_in, 1'b1);
    bus_wr(6'h34, 8'h00);
    bus_wr(6'h1C, 8'h3C);
    bus_wr(6'h20, 8'hCF);
    tick(2);
    check(analog_sel, 7'h00);
    check({pf_oe, pf_out & pf_oe}, 16'h3030);
    ext_f <= 8'h00;
    chk_rd(6'h18, 32'h0000_0030);
  endtask

  // ----------------------------------------------------------
  // Verdict, main sequence and watchdog
  // ----------------------------------------------------------
  task automatic test_done;
    if (errors == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    tick(3);
    rstn <= 1'b1;
    t_reset();
    t_dir_latch();
    t_psp();
    t_soft_reset();
    t_ccp_analog();
    test_done();
  end

  // The run needs well under a thousand cycles
  initial begin
    #1_000_000;
    errors++;
    test_done();
  end
endmodule // multiplexed_io_ports_d_e_f_bench

`default_nettype wire
